// file: verilog/ifhc_dev.sv
`timescale 1ns/1ns
// Function
// - header is 28 bytes, bits 223 to 0
// - bits 223:192 carry arrival time ns
// - inject: 191:181 zero, 53-bit port mask
// - builder zeroes every reserved field
// - tunnel: flag 189 updates hop count
// - tunnel: flag 188 exchanges MAC addresses
// - tunnel: 187:186 picks tag protocol identifier
// - tunnel: 10-bit generic index, kind bit 173
// - tunnel: payload offset 171:166, protection 172
// - tunnel: 165:163 payload kind, 6 reserved
// - tunnel: 162:147 classifier match result
// - tunnel: 146:139 label hop limit
// - tunnel: 138 last label bottom flag
// - tunnel: 134:133 header type after strip
// - tunnel: 132:128 halfwords stripped from start
// - unicast: leg 182:176, next-hop MAC
// - multicast: group 151:142, leg 141:135
// - multicast: 134:128 routed copy count
// - bits 127:48 hold stacking section
// - selector 40:38 picks destination format
module ifhc_dev #(
   parameter int FIFO_DEPTH = 32
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              srst,
   // link to the cpu end
   ifhc_if.dev_mp                 lk,
   // extraction header from the pipeline
   input  wire ifhc_pkg::ifhc_hdr_t x_hdr,
   input  wire logic              x_start,
   output logic                   x_busy,
   // injected header to the pipeline
   output ifhc_pkg::ifhc_hdr_t    i_hdr,
   output logic                   i_valid,
   input  wire logic              i_ready,
   // rewriter controls decoded from the injected header
   output logic                   i_hop_update,
   output logic                   i_mac_exchange,
   output logic [1:0]             i_tpid_select,
   output logic [5:0]             i_strip_bytes,
   output logic [7:0]             i_pdu_start_byte,
   output logic                   i_fmt_error
);
   typedef enum logic [1:0] {
      IFHC_TX_IDLE,
      IFHC_TX_SEND
   } ifhc_tx_t;

   typedef struct packed {
      ifhc_tx_t            tx_state;
      logic [4:0]          tx_cnt;
      ifhc_pkg::ifhc_word_t tx_sh;
      logic [4:0]          rx_cnt;
      ifhc_pkg::ifhc_word_t rx_sh;
      ifhc_pkg::ifhc_hdr_t hdr;
      logic                hdr_valid;
      logic [5:0]          strip_bytes;
      logic [7:0]          pdu_start;
      logic                fmt_error;
   } ifhc_dev_st_t;

   ifhc_dev_st_t         st;
   ifhc_dev_st_t         next_st;
   logic [8:0]           f_out;
   logic                 f_valid;
   logic                 f_ready;
   ifhc_pkg::ifhc_word_t rx_word;
   ifhc_pkg::ifhc_hdr_t  rx_hdr;
   logic                 rx_take;
   logic                 rx_done;

   // inbound bytes pass through the buffer; its ready stalls the cpu end
   ifhc_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .srst      (srst),
      .in_valid  (lk.i_valid),
      .in_ready  (lk.i_ready),
      .in_data   ({lk.i_first, lk.i_data}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_out)
   );

   // drain while no parsed header waits
   assign f_ready = !st.hdr_valid || i_ready;
   assign rx_take = f_valid && f_ready;
   assign rx_word = {st.rx_sh[`IFHC_HDR_BITS-`IFHC_BYTE_BITS-1:0], f_out[7:0]};
   assign rx_done = rx_take && !f_out[8] && (st.rx_cnt == `IFHC_CNT_FULL - 5'h01);
   assign rx_hdr  = ifhc_pkg::ifhc_unpack(rx_word);

   // outbound byte stream, top byte first
   assign lk.x_valid = st.tx_state == IFHC_TX_SEND;
   assign lk.x_first = st.tx_cnt == `IFHC_CNT_FULL;
   assign lk.x_data  = st.tx_sh[`IFHC_TOP_BYTE];
   assign x_busy     = st.tx_state != IFHC_TX_IDLE;

   // registered outputs toward the pipeline
   assign i_hdr            = st.hdr;
   assign i_valid          = st.hdr_valid;
   assign i_hop_update     = st.hdr.routed_update_flag;
   assign i_mac_exchange   = st.hdr.mac_exchange_flag;
   assign i_tpid_select    = st.hdr.tag_protocol_select;
   assign i_strip_bytes    = st.strip_bytes;
   assign i_pdu_start_byte = st.pdu_start;
   assign i_fmt_error      = st.fmt_error;

   // extraction: build the full header, then send it byte by byte
   always_comb
   begin
      next_st = st;
      case (st.tx_state)
         IFHC_TX_IDLE:
         begin
            if (x_start)
            begin
               next_st.tx_sh    = ifhc_pkg::ifhc_pack(x_hdr);
               next_st.tx_cnt   = `IFHC_CNT_FULL;
               next_st.tx_state = IFHC_TX_SEND;
            end
         end
         IFHC_TX_SEND:
         begin
            if (lk.x_ready)
            begin
               next_st.tx_sh  = st.tx_sh << `IFHC_BYTE_BITS;
               next_st.tx_cnt = st.tx_cnt - 5'h01;
               if (st.tx_cnt == `IFHC_CNT_ONE)
                  next_st.tx_state = IFHC_TX_IDLE;
            end
         end
         default: next_st.tx_state = IFHC_TX_IDLE;
      endcase

      // injection: a first-marked byte restarts assembly
      if (st.hdr_valid && i_ready)
         next_st.hdr_valid = 1'b0;
      if (rx_take)
      begin
         next_st.rx_sh = rx_word;
         if (f_out[8])
            next_st.rx_cnt = `IFHC_CNT_ONE;
         else if (st.rx_cnt != `IFHC_CNT_ZERO)
            next_st.rx_cnt = st.rx_cnt + 5'h01;
         if (rx_done)
         begin
            next_st.rx_cnt    = `IFHC_CNT_ZERO;
            next_st.hdr       = rx_hdr;
            next_st.hdr_valid = 1'b1;
            // halfword counts turned into bytes for the rewriter
            next_st.strip_bytes = {rx_hdr.halfword_strip_count, 1'b0};
            next_st.pdu_start   = {1'b0, rx_hdr.halfword_strip_count, 1'b0}
                                + {1'b0, rx_hdr.payload_halfword_offset, 1'b0};
            // reserved selector, payload kind or index kind in tunnel format
            next_st.fmt_error = (rx_hdr.destination_format > `IFHC_FMT_INJECT)
               || ((rx_hdr.destination_format == `IFHC_FMT_TUNNEL)
                   && ((rx_hdr.payload_kind == `IFHC_KIND_RSV)
                       || (rx_hdr.generic_index_kind == `IFHC_GKIND_RSV)));
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         st <= '0;
      else
         st <= next_st;
   end
endmodule // ifhc_dev

// file: verilog/ifhc_map.svh
`ifndef IFHC_MAP_SVH
`define IFHC_MAP_SVH
// header size and link byte width
`define IFHC_HDR_BYTES   28
`define IFHC_HDR_BITS    224
`define IFHC_BYTE_BITS   8
`define IFHC_TOP_BYTE    223:216
`define IFHC_CNT_FULL    5'h1c
`define IFHC_CNT_ONE     5'h01
`define IFHC_CNT_ZERO    5'h00
// common sections
`define IFHC_TS          223:192
`define IFHC_DST         191:128
`define IFHC_STACK       127:48
`define IFHC_LOW         47:0
`define IFHC_FMT         40:38
// inject format
`define IFHC_INJ_MASK    180:128
// tunnel rewrite format
`define IFHC_TR_UPD      189
`define IFHC_TR_SWAP     188
`define IFHC_TR_TPID     187:186
`define IFHC_TR_GIDX     183:174
`define IFHC_TR_GKIND    173
`define IFHC_TR_PROT     172
`define IFHC_TR_PDUOFS   171:166
`define IFHC_TR_KIND     165:163
`define IFHC_TR_CLS      162:147
`define IFHC_TR_TTL      146:139
`define IFHC_TR_SBIT     138
`define IFHC_TR_AFTER    134:133
`define IFHC_TR_STRIP    132:128
// unicast and multicast routing formats
`define IFHC_UC_LEG      182:176
`define IFHC_UC_MAC      175:128
`define IFHC_MC_GRP      151:142
`define IFHC_MC_LEG      141:135
`define IFHC_MC_COPY     134:128
// selector codes and checked values
`define IFHC_FMT_TUNNEL  3'h0
`define IFHC_FMT_UCAST   3'h1
`define IFHC_FMT_MCAST   3'h2
`define IFHC_FMT_INJECT  3'h3
`define IFHC_KIND_RSV    3'h6
`define IFHC_GKIND_RSV   1'h0
`endif

// file: verilog/ifhc_pkg.sv
package ifhc_pkg;
`include "ifhc_map.svh"

   typedef logic [`IFHC_HDR_BITS-1:0] ifhc_word_t;

   // all fields of every destination format
   typedef struct packed {
      logic [31:0] arrival_time_ns;
      logic [2:0]  destination_format;
      logic [52:0] port_mask;
      logic        routed_update_flag;
      logic        mac_exchange_flag;
      logic [1:0]  tag_protocol_select;
      logic [9:0]  generic_index;
      logic        generic_index_kind;
      logic        protection_on_flag;
      logic [5:0]  payload_halfword_offset;
      logic [2:0]  payload_kind;
      logic [15:0] classifier_match_result;
      logic [7:0]  label_hop_limit;
      logic        last_label_bottom_flag;
      logic [1:0]  payload_type_after_strip;
      logic [4:0]  halfword_strip_count;
      logic [6:0]  egress_router_leg;
      logic [47:0] next_hop_dest_mac;
      logic [9:0]  multicast_group_index;
      logic [6:0]  routed_copy_count;
      logic [79:0] stack_section;
      logic [47:0] low_fields;
   } ifhc_hdr_t;

   // build: unused and reserved bits stay zero
   function automatic ifhc_word_t ifhc_pack(input ifhc_hdr_t h);
      ifhc_word_t w;
      w = '0;
      w[`IFHC_TS]    = h.arrival_time_ns;
      w[`IFHC_STACK] = h.stack_section;
      w[`IFHC_LOW]   = h.low_fields;
      w[`IFHC_FMT]   = h.destination_format;
      case (h.destination_format)
         `IFHC_FMT_INJECT: w[`IFHC_INJ_MASK] = h.port_mask;
         `IFHC_FMT_TUNNEL:
         begin
            w[`IFHC_TR_UPD]    = h.routed_update_flag;
            w[`IFHC_TR_SWAP]   = h.mac_exchange_flag;
            w[`IFHC_TR_TPID]   = h.tag_protocol_select;
            w[`IFHC_TR_GIDX]   = h.generic_index;
            w[`IFHC_TR_GKIND]  = h.generic_index_kind;
            w[`IFHC_TR_PROT]   = h.protection_on_flag;
            w[`IFHC_TR_PDUOFS] = h.payload_halfword_offset;
            w[`IFHC_TR_KIND]   = h.payload_kind;
            w[`IFHC_TR_CLS]    = h.classifier_match_result;
            w[`IFHC_TR_TTL]    = h.label_hop_limit;
            w[`IFHC_TR_SBIT]   = h.last_label_bottom_flag;
            w[`IFHC_TR_AFTER]  = h.payload_type_after_strip;
            w[`IFHC_TR_STRIP]  = h.halfword_strip_count;
         end
         `IFHC_FMT_UCAST:
         begin
            w[`IFHC_UC_LEG] = h.egress_router_leg;
            w[`IFHC_UC_MAC] = h.next_hop_dest_mac;
         end
         `IFHC_FMT_MCAST:
         begin
            w[`IFHC_MC_GRP]  = h.multicast_group_index;
            w[`IFHC_MC_LEG]  = h.egress_router_leg;
            w[`IFHC_MC_COPY] = h.routed_copy_count;
         end
         default: w[`IFHC_DST] = '0;
      endcase
      return w;
   endfunction

   // parse: fields outside the selected format read zero
   function automatic ifhc_hdr_t ifhc_unpack(input ifhc_word_t w);
      ifhc_hdr_t h;
      h = '0;
      h.arrival_time_ns    = w[`IFHC_TS];
      h.stack_section      = w[`IFHC_STACK];
      h.low_fields         = w[`IFHC_LOW];
      h.destination_format = w[`IFHC_FMT];
      case (w[`IFHC_FMT])
         `IFHC_FMT_INJECT: h.port_mask = w[`IFHC_INJ_MASK];
         `IFHC_FMT_TUNNEL:
         begin
            h.routed_update_flag       = w[`IFHC_TR_UPD];
            h.mac_exchange_flag        = w[`IFHC_TR_SWAP];
            h.tag_protocol_select      = w[`IFHC_TR_TPID];
            h.generic_index            = w[`IFHC_TR_GIDX];
            h.generic_index_kind       = w[`IFHC_TR_GKIND];
            h.protection_on_flag       = w[`IFHC_TR_PROT];
            h.payload_halfword_offset  = w[`IFHC_TR_PDUOFS];
            h.payload_kind             = w[`IFHC_TR_KIND];
            h.classifier_match_result  = w[`IFHC_TR_CLS];
            h.label_hop_limit          = w[`IFHC_TR_TTL];
            h.last_label_bottom_flag   = w[`IFHC_TR_SBIT];
            h.payload_type_after_strip = w[`IFHC_TR_AFTER];
            h.halfword_strip_count     = w[`IFHC_TR_STRIP];
         end
         `IFHC_FMT_UCAST:
         begin
            h.egress_router_leg = w[`IFHC_UC_LEG];
            h.next_hop_dest_mac = w[`IFHC_UC_MAC];
         end
         `IFHC_FMT_MCAST:
         begin
            h.multicast_group_index = w[`IFHC_MC_GRP];
            h.egress_router_leg     = w[`IFHC_MC_LEG];
            h.routed_copy_count     = w[`IFHC_MC_COPY];
         end
         default: h.port_mask = '0;
      endcase
      return h;
   endfunction
endpackage

// file: verilog/ifhc_if.sv
`timescale 1ns/1ns
// byte streams: extract (device to cpu) and inject (cpu to device)
interface ifhc_if;
   logic       x_valid;
   logic       x_ready;
   logic       x_first;
   logic [7:0] x_data;
   logic       i_valid;
   logic       i_ready;
   logic       i_first;
   logic [7:0] i_data;
   modport dev_mp (output x_valid, x_first, x_data, i_ready,
                   input  x_ready, i_valid, i_first, i_data);
   modport cpu_mp (input  x_valid, x_first, x_data, i_ready,
                   output x_ready, i_valid, i_first, i_data);
endinterface

// file: verilog/ifhc_fifo.sv
`timescale 1ns/1ns
module ifhc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   count;
   } ifhc_fifo_st_t;

   ifhc_fifo_st_t    st;
   ifhc_fifo_st_t    next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // honest flags from the occupancy count
   assign in_ready  = st.count != (AW+1)'(DEPTH);
   assign out_valid = st.count != '0;
   assign out_data  = mem[st.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer and count update
   always_comb
   begin
      next_st = st;
      if (push)
         next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
      if (pop)
         next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         st <= '0;
      else
         st <= next_st;
      if (push)
         mem[st.wr] <= in_data;
   end
endmodule // ifhc_fifo

// file: verilog/ifhc_cpu.sv
`timescale 1ns/1ns
module ifhc_cpu (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              srst,
   // link to the device end
   ifhc_if.cpu_mp                 lk,
   // header to inject
   input  wire ifhc_pkg::ifhc_hdr_t i_hdr,
   input  wire logic              i_start,
   output logic                   i_busy,
   // extracted header received
   output ifhc_pkg::ifhc_hdr_t    x_hdr,
   output logic                   x_valid,
   input  wire logic              x_ready
);
   typedef struct packed {
      logic [4:0]           tx_cnt;
      ifhc_pkg::ifhc_word_t tx_sh;
      logic [4:0]           rx_cnt;
      ifhc_pkg::ifhc_word_t rx_sh;
      ifhc_pkg::ifhc_hdr_t  hdr;
      logic                 hdr_valid;
   } ifhc_cpu_st_t;

   ifhc_cpu_st_t         st;
   ifhc_cpu_st_t         next_st;
   ifhc_pkg::ifhc_word_t rx_word;
   logic                 rx_take;

   // inject stream, top byte first
   assign lk.i_valid = st.tx_cnt != `IFHC_CNT_ZERO;
   assign lk.i_first = st.tx_cnt == `IFHC_CNT_FULL;
   assign lk.i_data  = st.tx_sh[`IFHC_TOP_BYTE];
   assign i_busy     = lk.i_valid;

   // extract stream accepted while the last header is not pending
   assign lk.x_ready = !st.hdr_valid || x_ready;
   assign rx_take    = lk.x_valid && lk.x_ready;
   assign rx_word    = {st.rx_sh[`IFHC_HDR_BITS-`IFHC_BYTE_BITS-1:0], lk.x_data};
   assign x_hdr      = st.hdr;
   assign x_valid    = st.hdr_valid;

   // build and send, assemble and parse
   always_comb
   begin
      next_st = st;
      if (!lk.i_valid && i_start)
      begin
         next_st.tx_sh  = ifhc_pkg::ifhc_pack(i_hdr);
         next_st.tx_cnt = `IFHC_CNT_FULL;
      end
      else if (lk.i_valid && lk.i_ready)
      begin
         next_st.tx_sh  = st.tx_sh << `IFHC_BYTE_BITS;
         next_st.tx_cnt = st.tx_cnt - 5'h01;
      end
      if (st.hdr_valid && x_ready)
         next_st.hdr_valid = 1'b0;
      if (rx_take)
      begin
         next_st.rx_sh  = rx_word;
         if (lk.x_first || st.rx_cnt != `IFHC_CNT_ZERO)
            next_st.rx_cnt = lk.x_first ? `IFHC_CNT_ONE : st.rx_cnt + 5'h01;
         if (!lk.x_first && st.rx_cnt == `IFHC_CNT_FULL - 5'h01)
         begin
            next_st.rx_cnt    = `IFHC_CNT_ZERO;
            next_st.hdr       = ifhc_pkg::ifhc_unpack(rx_word);
            next_st.hdr_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         st <= '0;
      else
         st <= next_st;
   end
endmodule // ifhc_cpu

// file: tb/ifhc_monitor.sv
`timescale 1ns/1ns
module ifhc_monitor (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       srst,
   // extract stream
   input wire logic       x_valid,
   input wire logic       x_ready,
   input wire logic       x_first,
   input wire logic [7:0] x_data,
   // inject stream
   input wire logic       i_valid,
   input wire logic       i_ready,
   input wire logic       i_first,
   input wire logic [7:0] i_data
);
   logic [4:0] xcnt;
   logic [4:0] icnt;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   // bytes taken within the current header
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         xcnt <= 5'h00;
         icnt <= 5'h00;
      end
      else
      begin
         if (x_valid && x_ready)
            xcnt <= (xcnt == 5'h1b) ? 5'h00 : xcnt + 5'h01;
         if (i_valid && i_ready)
            icnt <= (icnt == 5'h1b) ? 5'h00 : icnt + 5'h01;
      end
   end

   property p_x_hold;
      x_valid && !x_ready |=> x_valid && $stable(x_data) && $stable(x_first);
   endproperty
   a_x_hold: assert property (p_x_hold)
      else $error("extract byte moved");
   property p_i_hold;
      i_valid && !i_ready |=> i_valid && $stable(i_data) && $stable(i_first);
   endproperty
   a_i_hold: assert property (p_i_hold)
      else $error("inject byte moved");
   property p_x_frame;
      x_valid |-> (x_first == (xcnt == 5'h00));
   endproperty
   a_x_frame: assert property (p_x_frame)
      else $error("extract first flag off byte zero");
   property p_i_frame;
      i_valid |-> (i_first == (icnt == 5'h00));
   endproperty
   a_i_frame: assert property (p_i_frame)
      else $error("inject first flag off byte zero");
   property p_x_flow;
      x_valid && x_ready && (xcnt != 5'h1b) |=> x_valid;
   endproperty
   a_x_flow: assert property (p_x_flow)
      else $error("extract header cut short");
   property p_i_flow;
      i_valid && i_ready && (icnt != 5'h1b) |=> i_valid;
   endproperty
   a_i_flow: assert property (p_i_flow)
      else $error("inject header cut short");
   property p_x_idle;
      $past(srst) |-> !x_valid;
   endproperty
   a_x_idle: assert property (p_x_idle)
      else $error("extract valid after reset");
   property p_i_rst;
      $past(srst) |-> i_ready && !i_valid;
   endproperty
   a_i_rst: assert property (p_i_rst)
      else $error("inject link not idle after reset");

   // main scenarios reached
   c_x_last: cover property (x_valid && x_ready && xcnt == 5'h1b);
   c_i_last: cover property (i_valid && i_ready && icnt == 5'h1b);
   c_i_full: cover property (i_valid && !i_ready);
endmodule // ifhc_monitor

// file: tb/internal_frame_header_codec_tb.sv
`timescale 1ns/1ns
module internal_frame_header_codec_tb;
   logic                core_clk = 1'b0;
   logic                srst = 1'b1;
   int                  error_cnt = 0;
   int                  samples_checked = 0;
   int                  cyc_cnt = 0;
   int                  cap_cnt = 0;
   int                  b_cnt = 0;
   bit                  hold = 1'b0;
   bit                  saw_full = 1'b0;
   logic [31:0]         rng = 32'h0001_2ae6;
   ifhc_pkg::ifhc_word_t cap_word = '0;
   ifhc_pkg::ifhc_hdr_t exp_q[$];
   ifhc_pkg::ifhc_hdr_t dx_hdr = '0, ci_hdr = '0, di_hdr, cx_hdr, b_hdr, b_last, rx_e;
   logic                dx_start = 1'b0, ci_start = 1'b0, di_ready = 1'b0, cx_ready = 1'b1;
   logic                dx_busy, ci_busy, di_valid, cx_valid, b_valid, d_hop, d_swap, d_err;
   logic [1:0]          d_tpid;
   logic [5:0]          d_strip;
   logic [7:0]          d_pdu;

   ifhc_if lk ();
   ifhc_if lk2 ();
   ifhc_dev u_ifhc_dev (.core_clk(core_clk), .srst(srst), .lk(lk.dev_mp), .x_hdr(dx_hdr),
      .x_start(dx_start), .x_busy(dx_busy), .i_hdr(di_hdr), .i_valid(di_valid),
      .i_ready(di_ready), .i_hop_update(d_hop), .i_mac_exchange(d_swap), .i_tpid_select(d_tpid),
      .i_strip_bytes(d_strip), .i_pdu_start_byte(d_pdu), .i_fmt_error(d_err));
   ifhc_cpu u_ifhc_cpu (.core_clk(core_clk), .srst(srst), .lk(lk.cpu_mp), .i_hdr(ci_hdr),
      .i_start(ci_start), .i_busy(ci_busy), .x_hdr(cx_hdr), .x_valid(cx_valid),
      .x_ready(cx_ready));
   // second device end fed raw bytes
   ifhc_dev u_ifhc_dev_b (.core_clk(core_clk), .srst(srst), .lk(lk2.dev_mp), .x_hdr('0),
      .x_start(1'b0), .x_busy(), .i_hdr(b_hdr), .i_valid(b_valid), .i_ready(1'b1),
      .i_hop_update(), .i_mac_exchange(), .i_tpid_select(), .i_strip_bytes(),
      .i_pdu_start_byte(), .i_fmt_error());
   ifhc_monitor u_ifhc_monitor (.core_clk(core_clk), .srst(srst), .x_valid(lk.x_valid),
      .x_ready(lk.x_ready), .x_first(lk.x_first), .x_data(lk.x_data), .i_valid(lk.i_valid),
      .i_ready(lk.i_ready), .i_first(lk.i_first), .i_data(lk.i_data));

   // clock and hang guard
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 10000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (error_cnt == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [351:0] e, input logic [351:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   // xorshift source
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   function automatic ifhc_pkg::ifhc_hdr_t rand_hdr(input logic [2:0] f);
      logic [351:0]        r;
      ifhc_pkg::ifhc_hdr_t h;
      for (int i = 0; i < 11; i++)
         r = {r[319:0], xs()};
      h = r[$bits(h)-1:0];
      h.destination_format = f;
      return h;
   endfunction

   // parsed view of a header
   function automatic ifhc_pkg::ifhc_hdr_t exp_hdr(input ifhc_pkg::ifhc_hdr_t h);
      ifhc_pkg::ifhc_hdr_t e;
      e = '0;
      case (h.destination_format)
         3'h0:
         begin
            e = h;
            {e.port_mask, e.egress_router_leg, e.next_hop_dest_mac, e.multicast_group_index,
               e.routed_copy_count} = '0;
         end
         3'h1:
         begin
            e.egress_router_leg = h.egress_router_leg;
            e.next_hop_dest_mac = h.next_hop_dest_mac;
         end
         3'h2:
         begin
            e.multicast_group_index = h.multicast_group_index;
            e.egress_router_leg = h.egress_router_leg;
            e.routed_copy_count = h.routed_copy_count;
         end
         3'h3: e.port_mask = h.port_mask;
         default: e.port_mask = '0;
      endcase
      e.arrival_time_ns = h.arrival_time_ns;
      e.destination_format = h.destination_format;
      e.stack_section = h.stack_section;
      e.low_fields = h.low_fields;
      e.low_fields[40:38] = h.destination_format;
      return e;
   endfunction

   // header as it must appear on the wire
   function automatic ifhc_pkg::ifhc_word_t exp_word(input ifhc_pkg::ifhc_hdr_t e);
      logic [63:0] d;
      case (e.destination_format)
         3'h0: d = {2'h0, e.routed_update_flag, e.mac_exchange_flag, e.tag_protocol_select,
            2'h0, e.generic_index, e.generic_index_kind, e.protection_on_flag,
            e.payload_halfword_offset, e.payload_kind, e.classifier_match_result,
            e.label_hop_limit, e.last_label_bottom_flag, 3'h0, e.payload_type_after_strip,
            e.halfword_strip_count};
         3'h1: d = {9'h000, e.egress_router_leg, e.next_hop_dest_mac};
         3'h2: d = {40'h00_0000_0000, e.multicast_group_index, e.egress_router_leg,
            e.routed_copy_count};
         3'h3: d = {11'h000, e.port_mask};
         default: d = '0;
      endcase
      return {e.arrival_time_ns, d, e.stack_section, e.low_fields};
   endfunction

   // extract past a start while busy; link may stall
   task automatic do_extract(input ifhc_pkg::ifhc_hdr_t h);
      @(negedge core_clk);
      while (dx_busy !== 1'b0)
         @(negedge core_clk);
      dx_hdr = h;
      dx_start = 1'b1;
      @(negedge core_clk);
      dx_hdr = rand_hdr(3'h1);
      @(negedge core_clk);
      dx_start = 1'b0;
      do
      begin
         @(negedge core_clk);
         cx_ready = 1'(xs());
      end
      while (dx_busy !== 1'b0 || cx_valid !== 1'b1);
      cmp("extract hdr", exp_hdr(h), cx_hdr);
      cmp("extract wire", exp_word(exp_hdr(h)), cap_word);
      cmp("extract bytes", 28, cap_cnt);
   endtask

   task automatic do_inject(input ifhc_pkg::ifhc_hdr_t h);
      @(negedge core_clk);
      while (ci_busy !== 1'b0)
         @(negedge core_clk);
      ci_hdr = h;
      ci_start = 1'b1;
      exp_q.push_back(exp_hdr(h));
      @(negedge core_clk);
      ci_start = 1'b0;
   endtask

   task automatic raw(input ifhc_pkg::ifhc_word_t w, input int n, input logic f);
      for (int k = 0; k < n; k++)
      begin
         @(negedge core_clk);
         lk2.i_valid = 1'b1;
         lk2.i_first = f && (k == 0);
         lk2.i_data = w[223 - 8 * k -: 8];
      end
      @(negedge core_clk);
      lk2.i_valid = 1'b0;
   endtask

   // wire capture and raw end results
   always @(posedge core_clk)
   begin
      if (!srst && lk.x_valid === 1'b1 && lk.x_ready === 1'b1)
      begin
         cap_word <= {cap_word[215:0], lk.x_data};
         cap_cnt <= lk.x_first ? 1 : cap_cnt + 1;
      end
      if (b_valid === 1'b1)
      begin
         b_cnt <= b_cnt + 1;
         b_last <= b_hdr;
      end
   end

   // injected header consumer
   always @(negedge core_clk)
   begin
      if (hold && lk.i_ready === 1'b0)
         saw_full = 1'b1;
      di_ready = hold ? 1'b0 : 1'(xs());
      if (!srst && di_valid === 1'b1 && di_ready === 1'b1)
      begin
         rx_e = exp_q.pop_front();
         cmp("inject hdr", rx_e, di_hdr);
         cmp("hop update", rx_e.routed_update_flag, d_hop);
         cmp("mac exchange", rx_e.mac_exchange_flag, d_swap);
         cmp("tpid select", rx_e.tag_protocol_select, d_tpid);
         cmp("strip bytes", {rx_e.halfword_strip_count, 1'b0}, d_strip);
         cmp("pdu start", 2 * (rx_e.halfword_strip_count + rx_e.payload_halfword_offset),
            d_pdu);
         cmp("fmt error", (rx_e.destination_format > 3'h3) || (rx_e.destination_format == 3'h0
            && (rx_e.payload_kind == 3'h6 || !rx_e.generic_index_kind)), d_err);
      end
   end

   initial
   begin
      ifhc_pkg::ifhc_hdr_t h;
      lk2.i_valid = 1'b0;
      lk2.i_first = 1'b0;
      lk2.i_data = 8'h00;
      lk2.x_ready = 1'b1;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      srst = 1'b0;
      for (int f = 0; f < 8; f++)
         do_extract(rand_hdr(3'(f)));
      for (int n = 0; n < 16; n++)
         do_inject(rand_hdr(3'(xs())));
      for (int k = 0; k < 3; k++)
      begin
         h = '1;
         h.destination_format = 3'h0;
         if (k == 1)
            h.payload_kind = 3'h6;
         if (k == 2)
            h.generic_index_kind = 1'b0;
         do_extract(h);
         do_inject(h);
      end
      wait (exp_q.size() == 0);
      hold = 1'b1;
      repeat (3) do_inject(rand_hdr(3'h3));
      repeat (40) @(negedge core_clk);
      cmp("fifo refused", 1, saw_full);
      hold = 1'b0;
      wait (exp_q.size() == 0);
      h = rand_hdr(3'h0);
      raw(exp_word(rand_hdr(3'h2)), 3, 1'b0);
      raw(exp_word(rand_hdr(3'h1)), 10, 1'b1);
      raw(exp_word(exp_hdr(h)) | (224'h7 << 135), 28, 1'b1);
      repeat (40) @(negedge core_clk);
      cmp("raw count", 1, b_cnt);
      cmp("raw hdr", exp_hdr(h), b_last);
      complete_run();
   end
endmodule // internal_frame_header_codec_tb
